// ---- src/sfe_pkg.sv ----
// Shared constants for the serial flash erase and power-down link
package sfe_pkg;
	// System clock and link timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned HALF_SCK_CYCLES = 8;
	localparam int unsigned T_DP_NS = 3000;
	localparam int unsigned T_RES_NS = 3000;
	localparam int unsigned T_SE_US = 1000;
	localparam int unsigned T_BE_US = 8000;
	localparam int unsigned DP_CYCLES =
		(T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RES_CYCLES =
		(T_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SE_CYCLES =
		(T_SE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BE_CYCLES =
		(T_BE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Command opcodes
	localparam logic [7:0] OP_WRITE_ARM = 8'h06;
	localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_SECTOR_WIPE_A = 8'h20;
	localparam logic [7:0] OP_SECTOR_WIPE_B = 8'hd8;
	localparam logic [7:0] OP_WHOLE_WIPE_A = 8'hc7;
	localparam logic [7:0] OP_WHOLE_WIPE_B = 8'h60;
	localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_PAR_ENTER = 8'h55;
	localparam logic [7:0] OP_PAR_EXIT = 8'h45;

	// Frame lengths in bytes, opcode included
	localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
	localparam logic [2:0] BYTES_SECTOR_WIPE = 3'h4;
	localparam logic [2:0] BYTES_BEFORE_SIG = 3'h4;

	// Device status byte and array layout
	localparam int unsigned SR_BUSY_BIT = 0;
	localparam int unsigned SR_LATCH_BIT = 1;
	localparam int unsigned SR_PROTECT_LSB = 2;
	localparam int unsigned SECTORS = 64;
	localparam int unsigned SECTOR_LSB = 18;
	localparam logic [63:0] BLANK_RST = 64'hffffffffffffffff;

	// Synchronised pin vector of the device: cs_n, sck, si
	localparam int unsigned PIN_CS = 2;
	localparam int unsigned PIN_SCK = 1;
	localparam int unsigned PIN_SI = 0;
	localparam logic [2:0] PIN_RST = 3'h4;

	// Host controller registers
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0c;
	localparam int unsigned CTRL_TXN_LSB = 8;
	localparam int unsigned CTRL_RXN_LSB = 10;
	localparam int unsigned CTRL_PAR_BIT = 12;
	localparam int unsigned STAT_BUSY_BIT = 0;
endpackage

// ---- src/sfe_link_if.sv ----
// Serial flash link between host controller and flash device
`timescale 1ns/1ns
interface sfe_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	logic [7:0] byte_lane_pins;
	logic lane_oe;
	modport device(input cs_n, input sck, input si, output so,
		output so_oe, output byte_lane_pins, output lane_oe);
	modport host(output cs_n, output sck, output si, input so,
		input so_oe, input byte_lane_pins, input lane_oe);
endinterface

// ---- src/sfe_device.sv ----
// Flash device end: erase, deep sleep, wake and signature commands
// Operation
// - Sector wipe, opcode 20h or D8h, erases sector
// - Erase needs write-arm latch set first
// - Host sends opcode plus three address bytes
// - Chip select rising off byte boundary discards
// - Erase starts on chip select rise; busy
// - Latch cleared before erase completes
// - Protected sector is never wiped
// - Whole wipe uses C7h or 60h
// - Whole wipe only with protect bits zero
// - Whole wipe is opcode only, starts on rise
// - In deep sleep only wake is heard
// - Deep sleep entered after entry delay
// - Standby whenever deselected and idle
// - Deep sleep refused while erasing
// - Reset always lands in ordinary standby
// - Wake returns to standby after wake delay
// - Signature after three dummies, falling edges
// - Signature repeats every eight clocks
// - Signature read ends on rise; standby
// - Parallel mode gives byte per clock
// - Host keeps clock within speed limits
// - Busy at status bit 0, latch bit 1
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module sfe_device #(
	parameter int unsigned SE_CYCLES = sfe_pkg::SE_CYCLES,
	parameter int unsigned BE_CYCLES = sfe_pkg::BE_CYCLES,
	parameter logic [7:0] SIGNATURE = 8'h5a // Arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	sfe_link_if.device link,
	input wire logic [2:0] protect_level_bits,
	input wire logic mark_used,
	input wire logic [5:0] mark_used_sector,
	output logic busy_flag,
	output logic write_arm_latch,
	output logic deep_sleep,
	output logic standby,
	output logic parallel_mode,
	output logic [63:0] sector_blank
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ERASE,
		ST_DP_ENTER,
		ST_DEEP,
		ST_WAKE
	} sfe_dev_state_e;

	sfe_dev_state_e state;
	logic [2:0] pin_in;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_f;
	logic [2:0] pin_v;
	logic cs_rise;
	logic cs_fall;
	logic sck_rise;
	logic sck_fall;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] shreg;
	logic [7:0] new_byte;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [23:0] timer;
	logic wipe_all;
	logic [5:0] wipe_sector;
	logic cmd_done;
	logic idle_cmd;
	logic is_sector_wipe;
	logic is_whole_wipe;
	logic [6:0] prot_floor;
	logic sector_protected;
	logic wipe_go;
	logic sleep_go;
	logic [7:0] status_byte;
	logic [7:0] out_byte;
	logic out_en;
	logic [2:0] out_bit;
	logic so_q;
	logic so_oe_q;
	logic [7:0] lane_q;
	logic lane_oe_q;

	assign pin_in = {link.cs_n, link.sck, link.si};

	// Three-stage synchronisers; a level counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1[g] <= sfe_pkg::PIN_RST[g];
					pin_s2[g] <= sfe_pkg::PIN_RST[g];
					pin_s3[g] <= sfe_pkg::PIN_RST[g];
					pin_f[g] <= sfe_pkg::PIN_RST[g];
				end else begin
					pin_s1[g] <= pin_in[g];
					pin_s2[g] <= pin_s1[g];
					pin_s3[g] <= pin_s2[g];
					pin_f[g] <= pin_v[g];
				end
			end
			assign pin_v[g] = (pin_s2[g] == pin_s3[g]) ? pin_s3[g] : pin_f[g];
		end
	endgenerate

	// Edges of the filtered link pins; the clock only counts inside a frame
	assign cs_rise = pin_v[sfe_pkg::PIN_CS] & ~pin_f[sfe_pkg::PIN_CS];
	assign cs_fall = ~pin_v[sfe_pkg::PIN_CS] & pin_f[sfe_pkg::PIN_CS];
	assign sck_rise = pin_v[sfe_pkg::PIN_SCK] & ~pin_f[sfe_pkg::PIN_SCK] &
		~pin_f[sfe_pkg::PIN_CS];
	assign sck_fall = ~pin_v[sfe_pkg::PIN_SCK] & pin_f[sfe_pkg::PIN_SCK] &
		~pin_f[sfe_pkg::PIN_CS];
	assign new_byte = {shreg[6:0], pin_v[sfe_pkg::PIN_SI]};

	// Input shifter: opcode byte, then up to three address or dummy bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			shreg <= 8'h00;
			opcode <= 8'h00;
			addr <= 24'h000000;
		end else if (cs_fall) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sck_rise) begin
			shreg <= new_byte;
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				// Saturates so an overlong frame never aliases a short one
				if (byte_cnt != 3'h7) begin
					byte_cnt <= byte_cnt + 3'h1;
				end
				if (byte_cnt == 3'h0) begin
					opcode <= new_byte;
				end else if (byte_cnt < sfe_pkg::BYTES_SECTOR_WIPE) begin
					addr <= {addr[15:0], new_byte};
				end
			end
		end
	end

	// A command counts only if deselect falls on a byte boundary
	assign cmd_done = cs_rise && bit_cnt == 3'h0 && byte_cnt != 3'h0;
	assign idle_cmd = cmd_done && state == ST_IDLE;
	assign is_sector_wipe = (opcode == sfe_pkg::OP_SECTOR_WIPE_A ||
		opcode == sfe_pkg::OP_SECTOR_WIPE_B) &&
		byte_cnt == sfe_pkg::BYTES_SECTOR_WIPE;
	assign is_whole_wipe = (opcode == sfe_pkg::OP_WHOLE_WIPE_A ||
		opcode == sfe_pkg::OP_WHOLE_WIPE_B) &&
		byte_cnt == sfe_pkg::BYTES_OPCODE_ONLY;

	// Upper part of the array is protected, growing with the level
	assign prot_floor = 7'h40 - (7'h01 << (protect_level_bits - 3'h1));
	assign sector_protected = protect_level_bits != 3'h0 &&
		{1'b0, addr[23:sfe_pkg::SECTOR_LSB]} >= prot_floor;

	assign wipe_go = idle_cmd && write_arm_latch &&
		((is_sector_wipe && !sector_protected) ||
		(is_whole_wipe && protect_level_bits == 3'h0));
	assign sleep_go = idle_cmd && opcode == sfe_pkg::OP_DEEP_SLEEP &&
		byte_cnt == sfe_pkg::BYTES_OPCODE_ONLY;

	// Operation sequencer with its own delay timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			timer <= 24'h000000;
			wipe_all <= 1'b0;
			wipe_sector <= 6'h00;
			busy_flag <= 1'b0;
			deep_sleep <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (wipe_go) begin
						state <= ST_ERASE;
						busy_flag <= 1'b1;
						wipe_all <= is_whole_wipe;
						wipe_sector <= addr[23:sfe_pkg::SECTOR_LSB];
						timer <= is_whole_wipe ? 24'(BE_CYCLES - 1) :
							24'(SE_CYCLES - 1);
					end else if (sleep_go) begin
						state <= ST_DP_ENTER;
						timer <= 24'(sfe_pkg::DP_CYCLES - 1);
					end
				end
				ST_ERASE: begin
					timer <= timer - 24'h000001;
					if (timer == 24'h000000) begin
						state <= ST_IDLE;
						busy_flag <= 1'b0;
					end
				end
				ST_DP_ENTER: begin
					timer <= timer - 24'h000001;
					if (timer == 24'h000000) begin
						state <= ST_DEEP;
						deep_sleep <= 1'b1;
					end
				end
				ST_DEEP: begin
					if (cmd_done && opcode == sfe_pkg::OP_WAKE) begin
						state <= ST_WAKE;
						timer <= 24'(sfe_pkg::RES_CYCLES - 1);
					end
				end
				ST_WAKE: begin
					timer <= timer - 24'h000001;
					if (timer == 24'h000000) begin
						state <= ST_IDLE;
						deep_sleep <= 1'b0;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Write-arm latch; dropped as soon as an erase is launched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_arm_latch <= 1'b0;
		end else if (wipe_go) begin
			write_arm_latch <= 1'b0;
		end else if (idle_cmd && byte_cnt == sfe_pkg::BYTES_OPCODE_ONLY) begin
			if (opcode == sfe_pkg::OP_WRITE_ARM) begin
				write_arm_latch <= 1'b1;
			end else if (opcode == sfe_pkg::OP_WRITE_DISARM) begin
				write_arm_latch <= 1'b0;
			end
		end
	end

	// Parallel mode persists until its exit command or reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parallel_mode <= 1'b0;
		end else if (idle_cmd && byte_cnt == sfe_pkg::BYTES_OPCODE_ONLY) begin
			if (opcode == sfe_pkg::OP_PAR_ENTER) begin
				parallel_mode <= 1'b1;
			end else if (opcode == sfe_pkg::OP_PAR_EXIT) begin
				parallel_mode <= 1'b0;
			end
		end
	end

	// Erased-sector map; a finishing erase wins over a same-cycle mark
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sector_blank <= sfe_pkg::BLANK_RST;
		end else begin
			if (mark_used) begin
				sector_blank[mark_used_sector] <= 1'b0;
			end
			if (state == ST_ERASE && timer == 24'h000000) begin
				if (wipe_all) begin
					sector_blank <= sfe_pkg::BLANK_RST;
				end else begin
					sector_blank[wipe_sector] <= 1'b1;
				end
			end
		end
	end

	// Standby once deselected with nothing running, any command included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby <= 1'b1;
		end else begin
			standby <= pin_f[sfe_pkg::PIN_CS] && state == ST_IDLE;
		end
	end

	// Status byte seen by the status read
	always_comb begin
		status_byte = 8'h00;
		status_byte[sfe_pkg::SR_BUSY_BIT] = busy_flag;
		status_byte[sfe_pkg::SR_LATCH_BIT] = write_arm_latch;
		status_byte[sfe_pkg::SR_PROTECT_LSB +: 3] = protect_level_bits;
	end

	// Status read is deaf in deep sleep; signature follows three dummies
	assign out_en = (opcode == sfe_pkg::OP_STATUS_READ && byte_cnt != 3'h0 &&
		state != ST_DEEP) || (opcode == sfe_pkg::OP_WAKE &&
		byte_cnt >= sfe_pkg::BYTES_BEFORE_SIG);
	assign out_byte = (opcode == sfe_pkg::OP_STATUS_READ) ? status_byte :
		SIGNATURE;

	// Output driver changes on the falling link clock, released on deselect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
			lane_q <= 8'h00;
			lane_oe_q <= 1'b0;
			out_bit <= 3'h0;
		end else if (pin_f[sfe_pkg::PIN_CS]) begin
			so_oe_q <= 1'b0;
			lane_oe_q <= 1'b0;
			out_bit <= 3'h0;
		end else if (sck_fall && out_en) begin
			if (parallel_mode) begin
				lane_q <= out_byte;
				lane_oe_q <= 1'b1;
			end else begin
				so_q <= out_byte[3'h7 - out_bit];
				so_oe_q <= 1'b1;
				out_bit <= out_bit + 3'h1;
			end
		end
	end

	assign link.so = so_q;
	assign link.so_oe = so_oe_q;
	assign link.byte_lane_pins = lane_q;
	assign link.lane_oe = lane_oe_q;
endmodule

// ---- src/sfe_host.sv ----
// Host controller end: APB-driven command framer for the serial flash
`timescale 1ns/1ns
module sfe_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sfe_link_if.host link
);
	typedef enum logic [2:0] {
		HS_IDLE,
		HS_LOW,
		HS_HIGH,
		HS_END,
		HS_GAP
	} sfe_host_state_e;

	sfe_host_state_e hstate;
	logic [12:0] ctrl;
	logic [23:0] addr_reg;
	logic [23:0] rxdata;
	logic busy;
	logic [8:0] rx_in;
	logic [8:0] rx_s1;
	logic [8:0] rx_s2;
	logic [8:0] rx_s3;
	logic [8:0] rx_f;
	logic [8:0] rx_v;
	logic [3:0] div;
	logic tick;
	logic [31:0] tx_sh;
	logic [5:0] clk_idx;
	logic [5:0] tx_clks;
	logic [5:0] all_clks;
	logic cs_q;
	logic sck_q;
	logic setup;
	logic access;
	logic start_ok;
	logic [31:0] rd_val;
	logic rd_err;

	// Three-stage synchronisers for the device's serial and lane outputs
	// A released line reads low, so a stale driven value is never taken
	assign rx_in = {link.byte_lane_pins & {8{link.lane_oe}},
		link.so & link.so_oe};
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rx_s1[g] <= 1'b0;
					rx_s2[g] <= 1'b0;
					rx_s3[g] <= 1'b0;
					rx_f[g] <= 1'b0;
				end else begin
					rx_s1[g] <= rx_in[g];
					rx_s2[g] <= rx_s1[g];
					rx_s3[g] <= rx_s2[g];
					rx_f[g] <= rx_v[g];
				end
			end
			assign rx_v[g] = (rx_s2[g] == rx_s3[g]) ? rx_s3[g] : rx_f[g];
		end
	endgenerate

	// APB decode; answer is prepared in the setup cycle
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign start_ok = access && pwrite && paddr == sfe_pkg::REG_CTRL && !busy;

	always_comb begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		case (paddr)
			sfe_pkg::REG_CTRL: rd_val = {19'h00000, ctrl};
			sfe_pkg::REG_ADDR: rd_val = {8'h00, addr_reg};
			sfe_pkg::REG_STATUS: rd_val[sfe_pkg::STAT_BUSY_BIT] = busy;
			sfe_pkg::REG_RXDATA: rd_val = {8'h00, rxdata};
			default: rd_err = 1'b1;
		endcase
		// A command write while a frame runs is refused
		if (pwrite && paddr == sfe_pkg::REG_CTRL && busy) begin
			rd_err = 1'b1;
		end
	end

	// Registered answer: one access cycle with pready high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && rd_err;
			prdata <= (setup && !pwrite) ? rd_val : 32'h00000000;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 13'h0000;
			addr_reg <= 24'h000000;
		end else if (access && pwrite) begin
			if (start_ok) begin
				ctrl <= pwdata[12:0];
			end
			if (paddr == sfe_pkg::REG_ADDR) begin
				addr_reg <= pwdata[23:0];
			end
		end
	end

	// Half-period divider of the link clock, reset at each state step
	assign tick = div == 4'(sfe_pkg::HALF_SCK_CYCLES - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 4'h0;
		end else if (hstate == HS_IDLE || tick) begin
			div <= 4'h0;
		end else begin
			div <= div + 4'h1;
		end
	end

	// Frame sequencer: deselect only after the last full byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hstate <= HS_IDLE;
			busy <= 1'b0;
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			tx_sh <= 32'h00000000;
			clk_idx <= 6'h00;
			tx_clks <= 6'h00;
			all_clks <= 6'h00;
			rxdata <= 24'h000000;
		end else begin
			case (hstate)
				HS_IDLE: begin
					if (start_ok) begin
						busy <= 1'b1;
						cs_q <= 1'b0;
						tx_sh <= {pwdata[7:0], addr_reg};
						clk_idx <= 6'h00;
						rxdata <= 24'h000000;
						tx_clks <= 6'h08 +
							{1'b0, pwdata[sfe_pkg::CTRL_TXN_LSB +: 2], 3'h0};
						all_clks <= 6'h08 +
							{1'b0, pwdata[sfe_pkg::CTRL_TXN_LSB +: 2], 3'h0} +
							(pwdata[sfe_pkg::CTRL_PAR_BIT] ?
							{4'h0, pwdata[sfe_pkg::CTRL_RXN_LSB +: 2]} :
							{1'b0, pwdata[sfe_pkg::CTRL_RXN_LSB +: 2], 3'h0});
						hstate <= HS_LOW;
					end
				end
				HS_LOW: begin
					if (tick) begin
						sck_q <= 1'b1;
						hstate <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (tick) begin
						// Sample late in the high half, well after the fall
						if (clk_idx >= tx_clks) begin
							rxdata <= ctrl[sfe_pkg::CTRL_PAR_BIT] ?
								{rxdata[15:0], rx_v[8:1]} :
								{rxdata[22:0], rx_v[0]};
						end
						sck_q <= 1'b0;
						tx_sh <= {tx_sh[30:0], 1'b0};
						clk_idx <= clk_idx + 6'h01;
						hstate <= (clk_idx == all_clks - 6'h01) ? HS_END : HS_LOW;
					end
				end
				HS_END: begin
					if (tick) begin
						cs_q <= 1'b1;
						hstate <= HS_GAP;
					end
				end
				HS_GAP: begin
					if (tick) begin
						busy <= 1'b0;
						hstate <= HS_IDLE;
					end
				end
				default: begin
					hstate <= HS_IDLE;
				end
			endcase
		end
	end

	// Clock rate is far below both speed limits of the link
	assign link.cs_n = cs_q;
	assign link.sck = sck_q;
	assign link.si = tx_sh[31];
endmodule

// ---- testbench/sfe_link_asserts.sv ----
// Concurrent checks on the flash link and the device state outputs
`timescale 1ns/1ns
module sfe_link_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic [7:0] byte_lane_pins,
	input wire logic lane_oe,
	input wire logic busy_flag,
	input wire logic write_arm_latch,
	input wire logic deep_sleep,
	input wire logic standby,
	input wire logic parallel_mode
);
	localparam int DPC = sfe_pkg::DP_CYCLES;
	logic [7:0] cs_hi;
	// Cycles since chip select rose; saturates so a long idle never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cs_hi <= 8'h00;
		else if (!cs_n)
			cs_hi <= 8'h00;
		else if (cs_hi != 8'hff)
			cs_hi <= cs_hi + 8'h01;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// One high half of the link clock, then the fall
	sequence sck_high_s;
		sck [*8] ##1 !sck;
	endsequence
	// Device moves its serial output
	sequence so_step_s;
		so_oe && $changed(so);
	endsequence
	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("link clock moved while deselected");
	sck_rate_a: assert property ($rose(sck) |-> sck_high_s)
		else $error("link clock high half not eight cycles");
	so_edge_a: assert property (so_step_s |-> !sck)
		else $error("serial output moved while clock high");
	so_release_a: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
		else $error("serial output still driven after deselect");
	lane_mode_a: assert property (lane_oe |-> parallel_mode)
		else $error("byte lane driven outside parallel mode");
	busy_start_a: assert property ($rose(busy_flag) |-> cs_n)
		else $error("erase began while selected");
	latch_clear_a: assert property ($fell(busy_flag) |-> !write_arm_latch)
		else $error("write arm latch set at erase end");
	sleep_entry_a: assert property ($rose(deep_sleep) |-> cs_hi >= DPC)
		else $error("deep sleep entered before entry delay");
	sleep_frame_a: assert property ($changed(deep_sleep) |-> cs_n)
		else $error("deep sleep changed while selected");
	sleep_idle_a: assert property (deep_sleep |-> !busy_flag)
		else $error("deep sleep during erase");
	standby_idle_a: assert property (standby |-> !busy_flag)
		else $error("standby while busy");
	active_sel_a: assert property ($fell(cs_n) |->
		##[1:8] (!standby || deep_sleep))
		else $error("standby kept after select");
endmodule

// ---- testbench/test_spi_flash_erase_powerdown.sv ----
// Self-checking bench: host and device ends joined over the flash link
`timescale 1ns/1ns
module test_spi_flash_erase_powerdown;
	localparam logic [7:0] SIG = 8'h5a; // Arbitrary signature value
	localparam logic [32:0] ALL = 33'h1ffffffff;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, b2, l2;
	logic mark_used = 1'h0;
	logic [5:0] mark_used_sector = 6'h00;
	logic [2:0] lvl = 3'h0;
	logic busy_flag, write_arm_latch, deep_sleep, standby, parallel_mode;
	logic [63:0] sector_blank;
	logic [32:0] exp_q[$], msk_q[$], e, m;
	int bad_count = 0;
	int samples_checked = 0;
	sfe_link_if lk();
	sfe_link_if lk2();
	sfe_host i_sfe_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk.host));
	// Erase times shortened, yet long enough to overlap a full command frame
	sfe_device #(.SE_CYCLES(400), .BE_CYCLES(600), .SIGNATURE(SIG))
		i_sfe_device (.pclk(pclk), .presetn(presetn), .link(lk.device),
		.protect_level_bits(lvl), .mark_used(mark_used),
		.mark_used_sector(mark_used_sector), .busy_flag(busy_flag),
		.write_arm_latch(write_arm_latch), .deep_sleep(deep_sleep),
		.standby(standby), .parallel_mode(parallel_mode),
		.sector_blank(sector_blank));
	// Second device, bit-banged so frames can be cut mid-byte
	sfe_device i_sfe_device_2 (.pclk(pclk), .presetn(presetn),
		.link(lk2.device), .protect_level_bits(3'h0), .mark_used(1'h0),
		.mark_used_sector(6'h00), .busy_flag(b2), .write_arm_latch(l2),
		.deep_sleep(), .standby(), .parallel_mode(), .sector_blank());
	sfe_link_asserts i_sfe_link_asserts (.pclk(pclk), .presetn(presetn),
		.cs_n(lk.cs_n), .sck(lk.sck), .si(lk.si), .so(lk.so),
		.so_oe(lk.so_oe), .byte_lane_pins(lk.byte_lane_pins),
		.lane_oe(lk.lane_oe), .busy_flag(busy_flag),
		.write_arm_latch(write_arm_latch), .deep_sleep(deep_sleep),
		.standby(standby), .parallel_mode(parallel_mode));
	// Bus clock
	always #25 pclk = ~pclk;
	task automatic chk(input string nm, input logic [63:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic give_up(input int n, lim);
		if (n >= lim) begin
			bad_count++;
			end_of_test();
		end
	endtask
	// One bus transfer; the expected answer is queued for the monitor
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] ex, mk,
		output logic [31:0] r);
		int n = 0;
		@(posedge pclk);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		give_up(n, 20);
	endtask
	// Answers are compared at the edge where the slave completes them
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk("apb answer", {pslverr, prdata} & m, e & m);
		end
	end
	task automatic host_wait;
		logic [31:0] r;
		int n = 0;
		do begin
			apb(1'h0, 8'h08, 32'h0, 33'h0, 33'h1fffffffe, r);
			n++;
		end while (r[0] !== 1'h0 && n < 1000);
		give_up(n, 1000);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [1:0] tn, rn,
		input logic p, input logic [23:0] ad, input logic [31:0] rx, rm);
		logic [31:0] r;
		apb(1'h1, 8'h04, {8'h00, ad}, 33'h0, ALL, r);
		apb(1'h1, 8'h00, {19'h0, p, rn, tn, op}, 33'h0, ALL, r);
		host_wait();
		if (rn != 2'h0)
			apb(1'h0, 8'h0c, 32'h0, {1'h0, rx}, {1'h0, rm}, r);
	endtask
	task automatic op1(input logic [7:0] op);
		cmd(op, 2'h0, 2'h0, 1'h0, 24'h0, 32'h0, 32'h0);
	endtask
	task automatic wipe(input logic [7:0] op, input logic [5:0] s);
		cmd(op, 2'h3, 2'h0, 1'h0, {s, 18'($urandom)}, 32'h0, 32'h0);
	endtask
	// Status byte low bits: busy, latch, protect level
	task automatic stat(input logic l, b);
		cmd(8'h05, 2'h0, 2'h1, 1'h0, 24'h0, {27'h0, lvl, l, b}, 32'h1f);
	endtask
	task automatic dev_wait;
		int n = 0;
		while (busy_flag !== 1'h0 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		give_up(n, 3000);
	endtask
	task automatic mark(input logic [5:0] s);
		@(posedge pclk);
		mark_used <= 1'h1;
		mark_used_sector <= s;
		@(posedge pclk);
		mark_used <= 1'h0;
	endtask
	// Hand-made frame of n bits, MSB first, on the second link
	task automatic bb(input logic [31:0] v, input int n);
		lk2.cs_n <= 1'h0;
		repeat (8) @(posedge pclk);
		for (int i = 31; i > 31 - n; i--) begin
			lk2.si <= v[i];
			repeat (8) @(posedge pclk);
			lk2.sck <= 1'h1;
			repeat (8) @(posedge pclk);
			lk2.sck <= 1'h0;
		end
		repeat (8) @(posedge pclk);
		lk2.cs_n <= 1'h1;
		repeat (16) @(posedge pclk);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		give_up(1, 0);
	end
	initial begin
		logic [5:0] s;
		logic [7:0] sw[2];
		logic [7:0] ww[2];
		logic [31:0] r;
		sw = '{8'h20, 8'hd8};
		ww = '{8'hc7, 8'h60};
		lk2.cs_n = 1'h1;
		lk2.sck = 1'h0;
		lk2.si = 1'h0;
		void'($urandom(32'h45506e20));
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("standby", standby, 1'h1);
		chk("blank", sector_blank, sfe_pkg::BLANK_RST);
		s = 6'($urandom_range(62));
		mark(s);
		wipe(8'h20, s);
		dev_wait();
		chk("unarmed", sector_blank[s], 1'h0);
		foreach (sw[i]) begin
			s = 6'($urandom_range(62));
			mark(s);
			op1(8'h06);
			stat(1'h1, 1'h0);
			wipe(sw[i], s);
			chk("busy", busy_flag, 1'h1);
			dev_wait();
			chk("wiped", sector_blank[s], 1'h1);
			stat(1'h0, 1'h0);
		end
		lvl <= 3'h1;
		mark(6'h3f);
		op1(8'h06);
		wipe(8'hd8, 6'h3f);
		dev_wait();
		chk("protected", sector_blank[63], 1'h0);
		op1(8'h06);
		op1(8'hc7);
		dev_wait();
		chk("whole held", sector_blank[63], 1'h0);
		lvl <= 3'h0;
		foreach (ww[i]) begin
			mark(6'h3f);
			op1(8'h06);
			op1(ww[i]);
			chk("whole busy", busy_flag, 1'h1);
			dev_wait();
			chk("whole", sector_blank, sfe_pkg::BLANK_RST);
		end
		// Sleep order sent while an erase still runs must be dropped
		mark(s);
		op1(8'h06);
		apb(1'h1, 8'h04, {8'h00, s, 18'h0}, 33'h0, ALL, r);
		apb(1'h1, 8'h00, 32'h320, 33'h0, ALL, r);
		apb(1'h1, 8'h00, 32'hb9, 33'h100000000, ALL, r);
		host_wait();
		op1(8'hb9);
		dev_wait();
		repeat (80) @(posedge pclk);
		chk("sleep refused", deep_sleep, 1'h0);
		chk("erase kept", sector_blank[s], 1'h1);
		op1(8'hb9);
		repeat (80) @(posedge pclk);
		chk("asleep", deep_sleep, 1'h1);
		op1(8'h06);
		chk("deaf latch", write_arm_latch, 1'h0);
		op1(8'hab);
		repeat (80) @(posedge pclk);
		chk("awake", {deep_sleep, standby}, 2'h1);
		cmd(8'hab, 2'h3, 2'h1, 1'h0, 24'h0, {24'h0, SIG}, 32'hff);
		cmd(8'hab, 2'h3, 2'h2, 1'h0, 24'h0, {16'h0, SIG, SIG}, 32'hffff);
		repeat (8) @(posedge pclk);
		chk("idle", standby, 1'h1);
		op1(8'h55);
		chk("parallel", parallel_mode, 1'h1);
		cmd(8'hab, 2'h3, 2'h2, 1'h1, 24'h0, {16'h0, SIG, SIG}, 32'hffff);
		op1(8'h45);
		chk("serial", parallel_mode, 1'h0);
		apb(1'h0, 8'h10, 32'h0, 33'h100000000, ALL, r);
		bb(32'h06000000, 8);
		chk("armed", l2, 1'h1);
		bb(32'h20000000, 28);
		chk("cut short", b2, 1'h0);
		bb(32'h20000000, 32);
		chk("whole frame", b2, 1'h1);
		op1(8'hb9);
		repeat (80) @(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("power up", {deep_sleep, standby, write_arm_latch}, 3'h2);
		end_of_test();
	end
endmodule
